// >>> rtl/adcsq_pkg.sv
// Package: control word layout, reset values and timing for the sequencer
package adcsq_pkg;

  typedef struct packed {
    logic write_en;
    logic sequencer_bit;
    logic [3:0] channel_addr_field;
    logic power_sel_hi;
    logic power_sel_lo;
    logic list_sel;
    logic idle_output_drive_sel;
    logic range_sel;
    logic coding_sel;
    logic single_or_diff_sel;
  } adcsq_ctrl_t;

  typedef enum logic [1:0] {
    ADCSQ_SPAN_REF = 2'h0,
    ADCSQ_SPAN_TWO_REF = 2'h1,
    ADCSQ_SPAN_HALF_PM = 2'h2,
    ADCSQ_SPAN_FULL_PM = 2'h3
  } adcsq_span_t;

  typedef enum logic [2:0] {
    ADCSQ_MODE_DIRECT = 3'h1,
    ADCSQ_MODE_LIST = 3'h2,
    ADCSQ_MODE_COUNT = 3'h4
  } adcsq_mode_t;

  typedef enum logic [2:0] {
    ADCSQ_ST_IDLE = 3'h1,
    ADCSQ_ST_FRAME = 3'h2,
    ADCSQ_ST_LIST_LOAD = 3'h4
  } adcsq_state_t;

  localparam int ADCSQ_CTRL_BITS = 13;
  localparam int ADCSQ_LIST_BITS = 16;
  localparam int ADCSQ_CONV_EDGES = 16;
  // Normal power, single-ended, straight binary after reset
  localparam logic [12:0] ADCSQ_CTRL_RST = 13'h0063;
  localparam logic [4:0] ADCSQ_CTRL_LAST = 5'h0c;
  localparam logic [4:0] ADCSQ_CONV_LAST = 5'h0f;
  localparam logic [4:0] ADCSQ_CNT_MAX = 5'h1f;
  localparam int ADCSQ_CLK_NS = 50;
  localparam int ADCSQ_WAKE_NS = 1000;
  localparam int ADCSQ_WAKE_CYC =
    (ADCSQ_WAKE_NS + ADCSQ_CLK_NS - 1) / ADCSQ_CLK_NS;
  localparam logic [4:0] ADCSQ_WAKE_LOAD = 5'(ADCSQ_WAKE_CYC);

endpackage

// >>> rtl/adcsq_chan_dec.sv
// Channel decoder: address code and input mode to multiplexer selects
`timescale 1ns/10ps
module adcsq_chan_dec #(
  parameter int NCH = 8
) (
  input wire logic [3:0] code,
  input wire logic single,
  output logic [2:0] pos_sel,
  output logic [2:0] neg_sel,
  output logic diff
);

  // Only the two documented variants have a decode table
  if (NCH != 4 && NCH != 8) begin : g_nch_check
    $error("adcsq_chan_dec: NCH must be 4 or 8");
  end

  logic [2:0] idx;

  always_comb begin
    // Upper address bits are don't-care for the variant
    if (NCH == 8) begin
      idx = code[2:0];
    end else begin
      idx = {1'b0, code[1:0]};
    end
    pos_sel = idx;
    // Odd code puts the odd input on the positive side
    neg_sel = idx ^ 3'h1;
    diff = ~single;
  end

endmodule

// >>> rtl/adcsq_core.sv
// Control word decode and channel sequencer for a multi-channel ADC
// Operation
// - Single-ended: range 1 spans 0..ref, range 0 spans 0..2*ref.
// - Differential: range 1 spans +-ref/2, range 0 spans +-ref.
// - Input chosen from address field plus single/differential bit.
// - Four-channel variant decodes two low address bits only.
// - Eight-channel variant decodes three low bits; odd code flips pair.
// - Both power bits set keeps the converter fully powered.
// - Upper power bit clear powers down after each conversion.
// - One microsecond wake-up before a valid conversion.
// - Sequencer bits 00: each conversion uses last written address.
// - Bits 01: next transfer loads channel list, then cycles it.
// - Any channel set, consecutive or not, is accepted in the list.
// - Bits 10: write changes settings without ending the sequence.
// - Bits 11: count channel 0 up to address field, then repeat.
// - Thirteen-bit word on first 13 falls; loaded only if write set.
// - Word order: write, seq, addr[3:0], power, list, drive, etc.
// - List cycles ascending from lowest until a non-10 write.
`timescale 1ns/10ps
module adcsq_core #(
  parameter int NCH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic din,
  output logic [2:0] mux_pos_q,
  output logic [2:0] mux_neg_q,
  output logic diff_q,
  output adcsq_pkg::adcsq_span_t span_q,
  output logic coding_binary_q,
  output logic idle_drive_q,
  output logic [3:0] result_addr_q,
  output logic conv_active_q,
  output logic powered_q,
  output logic awake_q
);

  if (NCH != 4 && NCH != 8) begin : g_nch_check
    $error("adcsq_core: NCH must be 4 or 8");
  end

  adcsq_pkg::adcsq_state_t state_q, state_d;
  adcsq_pkg::adcsq_mode_t mode_q, mode_d;
  adcsq_pkg::adcsq_ctrl_t ctrl_q, ctrl_d, word;
  logic [7:0] list_q, list_d;
  logic list_pend_q, list_pend_d;
  logic restart_q, restart_d;
  logic [2:0] idx_q, idx_d, nxt_idx;
  logic [4:0] cnt_q, cnt_d, wake_q, wake_d;
  logic [15:0] shift_q, shift_d;
  logic sclk_q, cs_q;
  logic cs_fall, cs_rise, sclk_fall;
  logic [3:0] code;
  logic [2:0] dec_pos, dec_neg;
  logic dec_diff;
  logic [2:0] mux_pos_d, mux_neg_d;
  logic diff_d, coding_binary_d, idle_drive_d, conv_active_d, powered_d;
  logic [3:0] result_addr_d;
  adcsq_pkg::adcsq_span_t span_d;

  function automatic adcsq_pkg::adcsq_span_t span_of(logic rng, logic se);
    if (se) begin
      span_of = rng ? adcsq_pkg::ADCSQ_SPAN_REF
                    : adcsq_pkg::ADCSQ_SPAN_TWO_REF;
    end else begin
      span_of = rng ? adcsq_pkg::ADCSQ_SPAN_HALF_PM
                    : adcsq_pkg::ADCSQ_SPAN_FULL_PM;
    end
  endfunction

  // Next set bit above cur, wrapping to the lowest; empty list -> top channel
  function automatic logic [2:0] list_next(logic [2:0] cur, logic [7:0] lst,
                                           logic rs);
    logic found;
    logic have_low;
    logic [2:0] low;
    found = 1'b0;
    have_low = 1'b0;
    low = 3'(NCH - 1);
    list_next = 3'(NCH - 1);
    for (int i = 0; i < NCH; i++) begin
      if (lst[i] && !have_low) begin
        have_low = 1'b1;
        low = 3'(i);
      end
      if (lst[i] && !found && (rs || 3'(i) > cur)) begin
        found = 1'b1;
        list_next = 3'(i);
      end
    end
    if (!found && have_low)
      list_next = low;
  endfunction

  assign cs_fall = cs_q & ~chip_select_n;
  assign cs_rise = ~cs_q & chip_select_n;
  assign sclk_fall = sclk_q & ~sclk & ~chip_select_n;
  assign word = adcsq_pkg::adcsq_ctrl_t'({shift_q[11:0], din});

  always_comb begin
    nxt_idx = idx_q;
    code = ctrl_q.channel_addr_field;
    unique case (mode_q)
      adcsq_pkg::ADCSQ_MODE_DIRECT: begin
        code = ctrl_q.channel_addr_field;
      end
      adcsq_pkg::ADCSQ_MODE_LIST: begin
        nxt_idx = list_next(idx_q, list_q, restart_q);
        code = {1'b0, nxt_idx};
      end
      adcsq_pkg::ADCSQ_MODE_COUNT: begin
        if (restart_q ||
            idx_q >= (ctrl_q.channel_addr_field[2:0] & 3'(NCH - 1)))
          nxt_idx = 3'h0;
        else
          nxt_idx = idx_q + 3'h1;
        code = {1'b0, nxt_idx};
      end
    endcase
  end

  adcsq_chan_dec #(.NCH(NCH)) u_dec (
    .code(code),
    .single(ctrl_q.single_or_diff_sel),
    .pos_sel(dec_pos),
    .neg_sel(dec_neg),
    .diff(dec_diff)
  );

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    ctrl_d = ctrl_q;
    list_d = list_q;
    list_pend_d = list_pend_q;
    restart_d = restart_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    wake_d = (wake_q != 5'h0) ? wake_q - 5'h1 : wake_q;
    shift_d = shift_q;
    mux_pos_d = mux_pos_q;
    mux_neg_d = mux_neg_q;
    diff_d = diff_q;
    span_d = span_q;
    coding_binary_d = coding_binary_q;
    idle_drive_d = idle_drive_q;
    result_addr_d = result_addr_q;
    conv_active_d = conv_active_q;
    powered_d = powered_q;
    if (cs_fall) begin
      // Settings freeze here so a write mid-frame hits the next one
      state_d = list_pend_q ? adcsq_pkg::ADCSQ_ST_LIST_LOAD
                            : adcsq_pkg::ADCSQ_ST_FRAME;
      list_pend_d = 1'b0;
      cnt_d = 5'h0;
      idx_d = nxt_idx;
      restart_d = 1'b0;
      mux_pos_d = dec_pos;
      mux_neg_d = dec_neg;
      diff_d = dec_diff;
      span_d = span_of(ctrl_q.range_sel, ctrl_q.single_or_diff_sel);
      coding_binary_d = ctrl_q.coding_sel;
      idle_drive_d = ctrl_q.idle_output_drive_sel;
      result_addr_d = code;
      conv_active_d = 1'b1;
      if (!powered_q) begin
        powered_d = 1'b1;
        wake_d = adcsq_pkg::ADCSQ_WAKE_LOAD;
      end
    end else if (sclk_fall && state_q != adcsq_pkg::ADCSQ_ST_IDLE) begin
      if (cnt_q != adcsq_pkg::ADCSQ_CNT_MAX)
        cnt_d = cnt_q + 5'h1;
      if (cnt_q <= adcsq_pkg::ADCSQ_CONV_LAST)
        shift_d = {shift_q[14:0], din};
      if (state_q == adcsq_pkg::ADCSQ_ST_FRAME &&
          cnt_q == adcsq_pkg::ADCSQ_CTRL_LAST && word.write_en) begin
        ctrl_d = word;
        unique case ({word.sequencer_bit, word.list_sel})
          2'b00: mode_d = adcsq_pkg::ADCSQ_MODE_DIRECT;
          2'b01: list_pend_d = 1'b1;
          2'b10: begin
            // Address stays; the running sequence is untouched
            ctrl_d.channel_addr_field = ctrl_q.channel_addr_field;
          end
          2'b11: begin
            mode_d = adcsq_pkg::ADCSQ_MODE_COUNT;
            restart_d = 1'b1;
          end
        endcase
      end
      if (cnt_q == adcsq_pkg::ADCSQ_CONV_LAST) begin
        conv_active_d = 1'b0;
        if (!ctrl_d.power_sel_hi)
          powered_d = 1'b0;
      end
    end else if (cs_rise) begin
      if (state_q == adcsq_pkg::ADCSQ_ST_LIST_LOAD &&
          cnt_q > adcsq_pkg::ADCSQ_CONV_LAST) begin
        // Channel 0 sits in the word's top bit
        for (int i = 0; i < 8; i++)
          list_d[i] = (i < NCH) ? shift_q[15 - i] : 1'b0;
        mode_d = adcsq_pkg::ADCSQ_MODE_LIST;
        restart_d = 1'b1;
      end
      state_d = adcsq_pkg::ADCSQ_ST_IDLE;
      conv_active_d = 1'b0;
    end
    if (ctrl_d.power_sel_hi && ctrl_d.power_sel_lo)
      powered_d = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= adcsq_pkg::ADCSQ_ST_IDLE;
      mode_q <= adcsq_pkg::ADCSQ_MODE_DIRECT;
      ctrl_q <= adcsq_pkg::adcsq_ctrl_t'(adcsq_pkg::ADCSQ_CTRL_RST);
      list_q <= 8'h00;
      list_pend_q <= 1'b0;
      restart_q <= 1'b0;
      idx_q <= 3'h0;
      cnt_q <= 5'h0;
      wake_q <= 5'h0;
      shift_q <= 16'h0000;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      mux_pos_q <= 3'h0;
      mux_neg_q <= 3'h1;
      diff_q <= 1'b0;
      span_q <= adcsq_pkg::ADCSQ_SPAN_TWO_REF;
      coding_binary_q <= 1'b1;
      idle_drive_q <= 1'b0;
      result_addr_q <= 4'h0;
      conv_active_q <= 1'b0;
      powered_q <= 1'b1;
      awake_q <= 1'b1;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
      list_q <= list_d;
      list_pend_q <= list_pend_d;
      restart_q <= restart_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      wake_q <= wake_d;
      shift_q <= shift_d;
      sclk_q <= sclk;
      cs_q <= chip_select_n;
      mux_pos_q <= mux_pos_d;
      mux_neg_q <= mux_neg_d;
      diff_q <= diff_d;
      span_q <= span_d;
      coding_binary_q <= coding_binary_d;
      idle_drive_q <= idle_drive_d;
      result_addr_q <= result_addr_d;
      conv_active_q <= conv_active_d;
      powered_q <= powered_d;
      awake_q <= powered_d && wake_d == 5'h0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_span_single: assert property (
    cs_fall && ctrl_q.single_or_diff_sel |=>
    span_q == (ctrl_q.range_sel ? adcsq_pkg::ADCSQ_SPAN_REF
                                : adcsq_pkg::ADCSQ_SPAN_TWO_REF))
    else $error("single-ended span wrong");
  a_span_diff: assert property (
    cs_fall && !ctrl_q.single_or_diff_sel |=>
    span_q == ($past(ctrl_q.range_sel) ? adcsq_pkg::ADCSQ_SPAN_HALF_PM
                                       : adcsq_pkg::ADCSQ_SPAN_FULL_PM))
    else $error("differential span wrong");
  a_pair_partner: assert property (
    mux_neg_q == (mux_pos_q ^ 3'h1))
    else $error("differential partner wrong");
  a_full_power: assert property (
    ctrl_q.power_sel_hi && ctrl_q.power_sel_lo |-> powered_q)
    else $error("powered down in normal mode");
  a_auto_down: assert property (
    sclk_fall && cnt_q == adcsq_pkg::ADCSQ_CONV_LAST &&
    state_q != adcsq_pkg::ADCSQ_ST_IDLE && !ctrl_d.power_sel_hi &&
    !cs_fall |=> !powered_q && !conv_active_q)
    else $error("no shutdown after conversion");
  a_wake_time: assert property (
    cs_fall && !powered_q |=> !awake_q [*8] ##[1:14] awake_q)
    else $error("wake-up interval wrong");
  a_direct_addr: assert property (
    cs_fall && mode_q == adcsq_pkg::ADCSQ_MODE_DIRECT |=>
    result_addr_q == $past(ctrl_q.channel_addr_field))
    else $error("direct address not used");
  // Thirteenth fall: first word bit sits in shift_q[11]
  a_no_write: assert property (
    sclk_fall && cnt_q == adcsq_pkg::ADCSQ_CTRL_LAST && !shift_q[11] &&
    state_q == adcsq_pkg::ADCSQ_ST_FRAME && !cs_fall
    |=> $stable(ctrl_q))
    else $error("control changed without write bit");
  a_hold_seq: assert property (
    sclk_fall && cnt_q == adcsq_pkg::ADCSQ_CTRL_LAST && !cs_fall &&
    state_q == adcsq_pkg::ADCSQ_ST_FRAME && shift_q[11:10] == 2'b11 &&
    !shift_q[3] |=> $stable(mode_q) && $stable(ctrl_q.channel_addr_field))
    else $error("sequence stopped by hold write");
  a_count_wrap: assert property (
    cs_fall && !restart_q &&
    mode_q == adcsq_pkg::ADCSQ_MODE_COUNT && idx_q == 3'h0 |=>
    idx_q <= 3'h1)
    else $error("counter step wrong");

  c_list_mode: cover property (mode_q == adcsq_pkg::ADCSQ_MODE_LIST
    && cs_fall);
  c_count_mode: cover property (mode_q == adcsq_pkg::ADCSQ_MODE_COUNT
    && cs_fall);
  c_wake: cover property (cs_fall && !powered_q ##[1:30] awake_q);

endmodule

// >>> verif/adcsq_host.sv
// Host serial port model: 16-bit frames, MSB first, sclk idle low
`timescale 1ns/10ps
module adcsq_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic slow,
  input wire logic [15:0] frame_word,
  output logic chip_select_n,
  output logic sclk,
  output logic din,
  output logic done
);
  logic [15:0] sh;
  logic [4:0] n;
  logic busy;
  logic gap;
  always @(negedge clock) begin
    done <= 1'b0;
    if (rst) begin
      chip_select_n <= 1'b1;
      sclk <= 1'b0;
      din <= 1'b0;
      busy <= 1'b0;
      gap <= 1'b0;
      n <= 5'h00;
    end else if (!busy) begin
      // Released line toggles so no stale bit can be mistaken for data
      din <= ~din;
      if (start && !done) begin
        busy <= 1'b1;
        chip_select_n <= 1'b0;
        sh <= frame_word;
        n <= 5'h00;
      end
    end else if (n == 5'h10) begin
      chip_select_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b1;
    end else if (slow && !gap && !sclk) begin
      gap <= 1'b1;
    end else if (!sclk) begin
      gap <= 1'b0;
      sclk <= 1'b1;
      din <= sh[15];
    end else begin
      sclk <= 1'b0;
      sh <= {sh[14:0], 1'b0};
      n <= n + 5'h01;
    end
  end
endmodule

// >>> verif/tb_top.sv
// Testbench: random and directed control frames against the sequencer
`timescale 1ns/10ps
module tb_top;
  logic clock, rst, start, slow, chip_select_n, sclk, din, done;
  logic [15:0] fw;
  logic [2:0] mux_pos_q, mux_neg_q;
  logic diff_q, coding_binary_q, idle_drive_q, conv_active_q;
  logic powered_q, awake_q;
  adcsq_pkg::adcsq_span_t span_q;
  logic [3:0] result_addr_q;
  logic [2:0] mux_pos4;
  logic [3:0] result_addr4;
  int err_total, total_checks;
  adcsq_host host (.clock(clock), .rst(rst), .start(start), .slow(slow),
    .frame_word(fw), .chip_select_n(chip_select_n), .sclk(sclk),
    .din(din), .done(done));
  adcsq_core #(.NCH(8)) dut (.clock(clock), .rst(rst),
    .chip_select_n(chip_select_n), .sclk(sclk), .din(din),
    .mux_pos_q(mux_pos_q), .mux_neg_q(mux_neg_q), .diff_q(diff_q),
    .span_q(span_q), .coding_binary_q(coding_binary_q),
    .idle_drive_q(idle_drive_q), .result_addr_q(result_addr_q),
    .conv_active_q(conv_active_q), .powered_q(powered_q),
    .awake_q(awake_q));
  // Four-channel variant on the same frames, for the two-bit decode
  adcsq_core #(.NCH(4)) dut4 (.clock(clock), .rst(rst),
    .chip_select_n(chip_select_n), .sclk(sclk), .din(din),
    .mux_pos_q(mux_pos4), .mux_neg_q(), .diff_q(), .span_q(),
    .coding_binary_q(), .idle_drive_q(), .result_addr_q(result_addr4),
    .conv_active_q(), .powered_q(), .awake_q());
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  function automatic logic [12:0] mk(logic we, logic sq, logic [3:0] a,
    logic [1:0] pm, logic ls, logic rg, logic se);
    return {we, sq, a, pm, ls, 1'b0, rg, 1'b1, se};
  endfunction
  function automatic logic [3:0] sp(logic rg, logic se);
    if (se)
      return rg ? 4'(adcsq_pkg::ADCSQ_SPAN_REF)
                : 4'(adcsq_pkg::ADCSQ_SPAN_TWO_REF);
    return rg ? 4'(adcsq_pkg::ADCSQ_SPAN_HALF_PM)
              : 4'(adcsq_pkg::ADCSQ_SPAN_FULL_PM);
  endfunction
  task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic frame(logic [15:0] v);
    int k;
    @(negedge clock);
    start <= 1'b1;
    fw <= v;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (done !== 1'b1 && k < 200);
    start <= 1'b0;
    if (k >= 200) chk("frame_done", 4'h1, 4'h0);
  endtask
  task automatic wr(logic [12:0] c);
    frame({c, 3'($urandom)});
  endtask
  task automatic sel(logic [2:0] p, logic df, logic [3:0] ra);
    chk("mux_pos", {1'b0, p}, {1'b0, mux_pos_q});
    chk("mux_neg", {1'b0, p ^ 3'h1}, {1'b0, mux_neg_q});
    chk("diff", {3'h0, df}, {3'h0, diff_q});
    chk("result_addr", ra, result_addr_q);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    err_total++;
    wrap_up();
  end
  initial begin
    logic [12:0] prev, c;
    logic [2:0] lst [3];
    int i, li;
    rst = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    fw = 16'h0000;
    err_total = 0;
    total_checks = 0;
    i = $urandom(89);
    lst = '{3'h1, 3'h4, 3'h6};
    repeat (20) @(negedge clock);
    rst <= 1'b0;
    @(negedge clock);
    sel(3'h0, 1'b0, 4'h0);
    chk("span", sp(1'b0, 1'b1), 4'(span_q));
    chk("powered", 4'h1, {3'h0, powered_q});
    $display("test reset done");
    prev = adcsq_pkg::ADCSQ_CTRL_RST;
    for (i = 0; i < 24; i++) begin
      c = mk(i % 5 != 4, 1'b0, 4'($urandom), 2'h3, 1'b0, 1'($urandom),
        1'($urandom));
      c[1] = 1'($urandom);
      c[3] = 1'($urandom);
      slow <= i[0];
      wr(c);
      sel(prev[9:7], !prev[0], prev[10:7]);
      chk("span", sp(prev[2], prev[0]), 4'(span_q));
      chk("coding", {3'h0, prev[1]}, {3'h0, coding_binary_q});
      chk("idle_drive", {3'h0, prev[3]}, {3'h0, idle_drive_q});
      chk("mux_pos4", {2'h0, prev[8:7]}, {1'b0, mux_pos4});
      chk("result_addr4", prev[10:7], result_addr4);
      chk("conv_active", 4'h0, {3'h0, conv_active_q});
      if (c[12]) prev = c;
    end
    slow <= 1'b0;
    $display("test direct done");
    wr(mk(1'b1, 1'b1, 4'ha, 2'h3, 1'b1, 1'b1, 1'b1));
    for (i = 0; i < 7; i++) begin
      wr(mk(1'b0, 1'b0, 4'h0, 2'h3, 1'b0, 1'b0, 1'b1));
      sel(3'(i % 3), 1'b0, 4'(i % 3));
    end
    $display("test counter done");
    wr(mk(1'b1, 1'b0, 4'h0, 2'h3, 1'b1, 1'b0, 1'b1));
    frame(16'h4a00);
    for (li = 0; li < 4; li++) begin
      wr(mk(1'b0, 1'b0, 4'h0, 2'h3, 1'b0, 1'b0, 1'b1));
      sel(lst[li % 3], 1'b0, {1'b0, lst[li % 3]});
    end
    wr(mk(1'b1, 1'b1, 4'h2, 2'h3, 1'b0, 1'b1, 1'b1));
    sel(lst[1], 1'b0, {1'b0, lst[1]});
    chk("span", sp(1'b0, 1'b1), 4'(span_q));
    wr(mk(1'b1, 1'b0, 4'h5, 2'h3, 1'b0, 1'b1, 1'b1));
    sel(lst[2], 1'b0, {1'b0, lst[2]});
    chk("span", sp(1'b1, 1'b1), 4'(span_q));
    wr(mk(1'b0, 1'b0, 4'h0, 2'h3, 1'b0, 1'b0, 1'b1));
    sel(3'h5, 1'b0, 4'h5);
    $display("test list done");
    wr(mk(1'b1, 1'b0, 4'h3, 2'h1, 1'b0, 1'b1, 1'b1));
    chk("powered", 4'h0, {3'h0, powered_q});
    fork
      wr(mk(1'b0, 1'b0, 4'h0, 2'h3, 1'b0, 1'b0, 1'b1));
      begin
        @(negedge chip_select_n);
        repeat (3) @(negedge clock);
        chk("powered", 4'h1, {3'h0, powered_q});
        chk("conv_active", 4'h1, {3'h0, conv_active_q});
        chk("awake", 4'h0, {3'h0, awake_q});
        repeat (20) @(negedge clock);
        chk("awake", 4'h1, {3'h0, awake_q});
      end
    join
    chk("powered", 4'h0, {3'h0, powered_q});
    wr(mk(1'b1, 1'b0, 4'h3, 2'h3, 1'b0, 1'b1, 1'b1));
    wr(mk(1'b0, 1'b0, 4'h0, 2'h3, 1'b0, 1'b0, 1'b1));
    chk("powered", 4'h1, {3'h0, powered_q});
    $display("test power done");
    wrap_up();
  end
endmodule
